// [plotter_cfg.svh]
`ifndef PLOTTER_CFG_SVH
`define PLOTTER_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CMD 8'h00
`define REG_FUNC 8'h04
`define REG_STATUS 8'h08
`define REG_CFG 8'h0c
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_CLR 8'h14
`define REG_IRQ_EN 8'h18

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define CMD_W 6
`define FUNC_LSB 8
`define FUNC_START_BIT 0
`define FUNC_CLEAR_BIT 1
`define BIT_X_PLUS 0
`define BIT_X_MINUS 1
`define BIT_Y_PLUS 2
`define BIT_Y_MINUS 3
`define BIT_PEN_LOWER 4
`define BIT_PEN_RAISE 5
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_MOVING 2
`define CFG_FAST 0
`define IRQ_DONE 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CMD_RESET 6'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 50
`define AXIS_SLOW_US 5000
`define AXIS_FAST_US 3300
`define PEN_US 100000
`define AXIS_SLOW_CYC (`AXIS_SLOW_US * `CLK_MHZ)
`define AXIS_FAST_CYC (`AXIS_FAST_US * `CLK_MHZ)
`define PEN_CYC (`PEN_US * `CLK_MHZ)

`endif

// [plotter_controller_unit.sv]
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "plotter_cfg.svh"

// Overview of operation
// - A command load copies accumulator bits 10-15 into the buffer.
// - Start sets busy, clears done and forwards the buffer to the plotter.
// - Step completion clears busy, sets done and requests an interrupt.
// - Start leaves the buffer alone, so repeated starts repeat the step.
// - Each start yields exactly one step in the encoded directions.
// - Execution time runs from the start until done becomes 1.
// - At 200 steps per second an axis step completes in 5 ms.
// - At 300 steps per second an axis step completes in 3.3 ms.
// - Any pen raise or lower takes 100 ms whatever the speed.
// - Plus and minus together on one axis give no motion on that axis.
// - A non-contradictory movement is still carried out beside one.
// - Pen motion with an axis step in one command draws a short segment.
// - Clear zeroes busy and done and leaves the buffer unaltered.
// - The buffer holds six bits, two for each of x, y and pen.
module plotter_controller_unit #(
	parameter int AXIS_SLOW_CYC = `AXIS_SLOW_CYC,
	parameter int AXIS_FAST_CYC = `AXIS_FAST_CYC,
	parameter int PEN_CYC = `PEN_CYC,
	parameter int CNT_W = 23
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [7:0] s_axi_araddr_in,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic x_plus_out,
	output logic x_minus_out,
	output logic y_plus_out,
	output logic y_minus_out,
	output logic pen_lower_out,
	output logic pen_raise_out,
	output logic busy_out,
	output logic done_out,
	output logic irq_out
);

	initial
	begin
		if (AXIS_SLOW_CYC < 1 || AXIS_FAST_CYC < 1 || PEN_CYC < 1)
			$error("plotter_controller_unit: step times must be positive");
		if (CNT_W > 31 || PEN_CYC >= (1 << CNT_W) ||
			AXIS_SLOW_CYC >= (1 << CNT_W) || AXIS_FAST_CYC >= (1 << CNT_W))
			$error("plotter_controller_unit: CNT_W too narrow");
	end

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic rd_fire;
	logic wr_ok;
	logic [31:0] rd_data;
	logic rd_ok;

	// Address and data are caught independently, in either order
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
	assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `RESP_OKAY;
		end
		else if (ce_in)
		begin
			s_axi_awready_out <= !aw_have_q && !s_axi_awready_out;
			s_axi_wready_out <= !w_have_q && !s_axi_wready_out;
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bvalid_out && s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	always_comb
	begin
		case ({aw_addr_q[7:2], 2'b00})
			`REG_CMD, `REG_FUNC, `REG_CFG, `REG_IRQ_CLR, `REG_IRQ_EN:
				wr_ok = 1'b1;
			default:
				wr_ok = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Command buffer and functions
	// ------------------------------------------------------------------
	logic [`CMD_W-1:0] cmd_q;
	logic cmd_wr;
	logic [1:0] func;
	logic start_fire;
	logic clear_fire;
	logic [`CMD_W-1:0] cmd_now;
	logic speed_fast_q;

	assign cmd_wr = wr_fire && ({aw_addr_q[7:2], 2'b00} == `REG_CMD) &&
		w_strb_q[0];
	// A load may carry a function in its second byte; a plain function
	// register gives the same functions without touching the buffer
	always_comb
	begin
		func = 2'b00;
		if (wr_fire && w_strb_q[1] &&
			({aw_addr_q[7:2], 2'b00} == `REG_CMD ||
			{aw_addr_q[7:2], 2'b00} == `REG_FUNC))
			func = w_data_q[`FUNC_LSB +: 2];
	end
	assign start_fire = func[`FUNC_START_BIT] && ce_in;
	assign clear_fire = func[`FUNC_CLEAR_BIT] && !func[`FUNC_START_BIT] &&
		ce_in;
	// Accumulator bit 15 is the least significant, so bits 10-15 are the
	// low six bits of the written word
	assign cmd_now = cmd_wr ? w_data_q[`CMD_W-1:0] : cmd_q;

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			cmd_q <= `CMD_RESET;
		else if (ce_in && cmd_wr)
			cmd_q <= w_data_q[`CMD_W-1:0];
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			speed_fast_q <= 1'b0;
		else if (ce_in && wr_fire && w_strb_q[0] &&
			{aw_addr_q[7:2], 2'b00} == `REG_CFG)
			speed_fast_q <= w_data_q[`CFG_FAST];
	end

	// ------------------------------------------------------------------
	// Direction decode and step issue
	// ------------------------------------------------------------------
	logic x_p;
	logic x_m;
	logic y_p;
	logic y_m;
	logic pen_l;
	logic pen_r;
	logic pen_any;
	logic [CNT_W-1:0] step_cnt;
	logic expire;
	plotter_pkg::step_state_t state_q;

	assign x_p = cmd_now[`BIT_X_PLUS] && !cmd_now[`BIT_X_MINUS];
	assign x_m = cmd_now[`BIT_X_MINUS] && !cmd_now[`BIT_X_PLUS];
	assign y_p = cmd_now[`BIT_Y_PLUS] && !cmd_now[`BIT_Y_MINUS];
	assign y_m = cmd_now[`BIT_Y_MINUS] && !cmd_now[`BIT_Y_PLUS];
	assign pen_l = cmd_now[`BIT_PEN_LOWER] && !cmd_now[`BIT_PEN_RAISE];
	assign pen_r = cmd_now[`BIT_PEN_RAISE] && !cmd_now[`BIT_PEN_LOWER];
	assign pen_any = cmd_now[`BIT_PEN_LOWER] || cmd_now[`BIT_PEN_RAISE];

	// Any pen bit costs the full pen time, even when it cancels out
	always_comb
	begin
		if (pen_any)
			step_cnt = CNT_W'(PEN_CYC);
		else if (speed_fast_q)
			step_cnt = CNT_W'(AXIS_FAST_CYC);
		else
			step_cnt = CNT_W'(AXIS_SLOW_CYC);
	end

	step_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.load_in(start_fire),
		.abort_in(clear_fire),
		.count_in(step_cnt),
		.expire_out(expire)
	);

	// Pen and axis pulses leave together, so the axis moves while the pen
	// travels and only part of the step is inked
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			x_plus_out <= 1'b0;
			x_minus_out <= 1'b0;
			y_plus_out <= 1'b0;
			y_minus_out <= 1'b0;
			pen_lower_out <= 1'b0;
			pen_raise_out <= 1'b0;
		end
		else if (ce_in)
		begin
			x_plus_out <= start_fire && x_p;
			x_minus_out <= start_fire && x_m;
			y_plus_out <= start_fire && y_p;
			y_minus_out <= start_fire && y_m;
			pen_lower_out <= start_fire && pen_l;
			pen_raise_out <= start_fire && pen_r;
		end
	end

	// ------------------------------------------------------------------
	// Busy, done and interrupt
	// ------------------------------------------------------------------
	logic irq_stat_q;
	logic irq_en_q;
	logic irq_clr;

	// A completion in a clear's cycle is dropped; a start in the same cycle
	// as a completion begins the new step instead
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			busy_out <= 1'b0;
			done_out <= 1'b0;
			state_q <= plotter_pkg::ST_IDLE;
		end
		else if (ce_in)
		begin
			if (start_fire)
			begin
				busy_out <= 1'b1;
				done_out <= 1'b0;
				state_q <= plotter_pkg::ST_MOVING;
			end
			else if (expire)
			begin
				busy_out <= 1'b0;
				done_out <= 1'b1;
				state_q <= plotter_pkg::ST_IDLE;
			end
			else if (clear_fire)
			begin
				busy_out <= 1'b0;
				done_out <= 1'b0;
				state_q <= plotter_pkg::ST_IDLE;
			end
		end
	end

	assign irq_clr = wr_fire && w_strb_q[0] &&
		{aw_addr_q[7:2], 2'b00} == `REG_IRQ_CLR && w_data_q[`IRQ_DONE];

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			irq_stat_q <= 1'b0;
			irq_en_q <= 1'b0;
			irq_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (expire && !start_fire)
				irq_stat_q <= 1'b1;
			else if (irq_clr)
				irq_stat_q <= 1'b0;
			if (wr_fire && w_strb_q[0] &&
				{aw_addr_q[7:2], 2'b00} == `REG_IRQ_EN)
				irq_en_q <= w_data_q[`IRQ_DONE];
			irq_out <= (irq_stat_q || (expire && !start_fire)) && irq_en_q;
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		case ({s_axi_araddr_in[7:2], 2'b00})
			`REG_CMD: rd_data[`CMD_W-1:0] = cmd_q;
			`REG_FUNC, `REG_IRQ_CLR: rd_data = 32'h0000_0000;
			`REG_STATUS:
			begin
				rd_data[`STAT_BUSY] = busy_out;
				rd_data[`STAT_DONE] = done_out;
				rd_data[`STAT_MOVING] = state_q == plotter_pkg::ST_MOVING;
			end
			`REG_CFG: rd_data[`CFG_FAST] = speed_fast_q;
			`REG_IRQ_STAT: rd_data[`IRQ_DONE] = irq_stat_q;
			`REG_IRQ_EN: rd_data[`IRQ_DONE] = irq_en_q;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= `RESP_OKAY;
		end
		else if (ce_in)
		begin
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
			if (rd_fire)
			begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_data;
				s_axi_rresp_out <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rvalid_out && s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [CNT_W-1:0] elapsed_q;
	logic [CNT_W-1:0] expect_q;
	logic [`CMD_W-1:0] issued_q;

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			elapsed_q <= '0;
			expect_q <= '0;
			issued_q <= '0;
		end
		else if (ce_in)
		begin
			if (start_fire)
			begin
				elapsed_q <= '0;
				expect_q <= step_cnt;
				issued_q <= cmd_now;
			end
			else if (busy_out)
				elapsed_q <= elapsed_q + CNT_W'(1);
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);

	sequence seq_start;
		start_fire;
	endsequence
	sequence seq_flags_moving;
		busy_out && !done_out;
	endsequence

	AST_LOAD: assert property (cmd_wr && ce_in |=>
		cmd_q == $past(w_data_q[5:0]))
		else $error("command buffer not loaded from low six bits");
	AST_START: assert property (seq_start |=> seq_flags_moving)
		else $error("start did not set busy and clear done");
	AST_DONE: assert property (expire && !start_fire && ce_in |=>
		done_out && !busy_out && irq_stat_q)
		else $error("completion did not set done and request");
	AST_KEEP: assert property (start_fire && !cmd_wr |=>
		$stable(cmd_q))
		else $error("start altered the command buffer");
	AST_ONE: assert property ($rose(x_plus_out || y_plus_out) |->
		$past(start_fire))
		else $error("step pulse without a start");
	AST_TIME: assert property ($rose(done_out) |->
		elapsed_q == expect_q)
		else $error("step time differs from its speed figure");
	AST_CONTRA: assert property (x_plus_out || x_minus_out |->
		!(issued_q[0] && issued_q[1]))
		else $error("motion on a contradictory x axis");
	AST_OTHER: assert property (seq_start and (ce_in &&
		cmd_now[0] && cmd_now[1] && cmd_now[2] && !cmd_now[3]) |=>
		y_plus_out && !x_plus_out && !x_minus_out)
		else $error("valid y step dropped beside contradictory x");
	AST_DOT: assert property (pen_lower_out |->
		x_plus_out == (issued_q[0] && !issued_q[1]))
		else $error("axis step not issued with the pen motion");
	AST_CLEAR: assert property (clear_fire && !expire && !cmd_wr |=>
		!busy_out && !done_out && $stable(cmd_q))
		else $error("clear did not idle the controller");
	AST_RESET: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		reset_in |=> !busy_out && !done_out && !irq_out)
		else $error("reset left flags or interrupt set");

endmodule

// [plotter_mechanism_model.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Pen carriage stand-in
// ----------------------------------------------------------------------
// Integrates step pulses into a position and counts every pulse line
// separately. Plus and minus together would cancel in the position, so
// the pulse count is what exposes a pair that should never have been sent.
module plotter_mechanism_model (
	input wire logic sys_clk_in,
	input wire logic x_plus_in,
	input wire logic x_minus_in,
	input wire logic y_plus_in,
	input wire logic y_minus_in,
	input wire logic pen_lower_in,
	input wire logic pen_raise_in,
	output int x_pos_out,
	output int y_pos_out,
	output int pulse_cnt_out,
	output int combo_cnt_out,
	output logic pen_down_out
);
	logic axis_move;

	assign axis_move = x_plus_in || x_minus_in || y_plus_in || y_minus_in;

	always_ff @(posedge sys_clk_in)
	begin
		x_pos_out <= x_pos_out + (x_plus_in ? 1 : 0) - (x_minus_in ? 1 : 0);
		y_pos_out <= y_pos_out + (y_plus_in ? 1 : 0) - (y_minus_in ? 1 : 0);
		pulse_cnt_out <= pulse_cnt_out + $countones({x_plus_in, x_minus_in,
			y_plus_in, y_minus_in, pen_lower_in, pen_raise_in});
		if ((pen_lower_in || pen_raise_in) && axis_move)
			combo_cnt_out <= combo_cnt_out + 1;
		if (pen_lower_in)
			pen_down_out <= 1'h1;
		else if (pen_raise_in)
			pen_down_out <= 1'h0;
	end
endmodule

// [plotter_pkg.sv]
package plotter_pkg;

	typedef enum {ST_IDLE, ST_MOVING} step_state_t;

	typedef enum {SPEED_SLOW, SPEED_FAST} speed_t;

endpackage

// [step_timer.sv]
`timescale 1ns/10ps

// Counts a loaded number of enabled cycles and pulses expire_out in the
// last one, so the owner's flag changes exactly count edges after load.
module step_timer #(
	parameter int CNT_W = 23
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic load_in,
	input wire logic abort_in,
	input wire logic [CNT_W-1:0] count_in,
	output logic expire_out
);

	logic [CNT_W-1:0] cnt_q;
	logic run_q;

	initial
	begin
		if (CNT_W < 2 || CNT_W > 31)
			$error("step_timer: CNT_W out of range");
	end

	assign expire_out = run_q && (cnt_q == CNT_W'(1)) && !load_in && !abort_in;

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end
		else if (ce_in)
		begin
			if (load_in)
			begin
				cnt_q <= count_in;
				run_q <= 1'b1;
			end
			else if (abort_in || expire_out)
				run_q <= 1'b0;
			else if (run_q)
				cnt_q <= cnt_q - CNT_W'(1);
		end
	end

endmodule

// [tb_plotter_controller_unit.sv]
`timescale 1ns/10ps

module tb_plotter_controller_unit;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic awv = 1'h0;
	logic wv = 1'h0;
	logic bre = 1'h0;
	logic arv = 1'h0;
	logic rre = 1'h0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'h0;
	logic awr, wr, bv, arr, rv, xp, xm, yp, ym, pl, pr, busy, done, irq;
	logic [1:0] br, rr, r;
	logic [31:0] rd, d;
	logic pd;
	int xq, yq, pc, cc;
	int n_errors = 0;
	int cmp_count = 0;
	int ex = 0;
	int ey = 0;
	int ep = 0;

	always #10 clk = ~clk;

	plotter_controller_unit #(.AXIS_SLOW_CYC(20), .AXIS_FAST_CYC(13),
		.PEN_CYC(40), .CNT_W(23)) u_dut (
		.sys_clk_in(clk), .reset_in(rst), .ce_in(ce),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bre), .s_axi_bresp_out(br),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rre), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
		.x_plus_out(xp), .x_minus_out(xm), .y_plus_out(yp),
		.y_minus_out(ym), .pen_lower_out(pl), .pen_raise_out(pr),
		.busy_out(busy), .done_out(done), .irq_out(irq));

	plotter_mechanism_model u_mech (
		.sys_clk_in(clk), .x_plus_in(xp), .x_minus_in(xm), .y_plus_in(yp),
		.y_minus_in(ym), .pen_lower_in(pl), .pen_raise_in(pr),
		.x_pos_out(xq), .y_pos_out(yq), .pulse_cnt_out(pc),
		.combo_cnt_out(cc), .pen_down_out(pd));

	// ------------------------------------------------------------------
	// Bus tasks: outputs are registered, so sampling at the falling edge
	// sees a value that holds through the next rising edge
	// ------------------------------------------------------------------
	task automatic end_of_test;
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat,
		output logic [1:0] resp);
		logic ah;
		logic wh;
		@(posedge clk);
		awv <= 1'h1;
		awa <= a;
		wv <= 1'h1;
		wd <= dat;
		ws <= 4'hf;
		bre <= 1'h1;
		@(negedge clk);
		while (awv || wv)
		begin
			ah = awv && awr;
			wh = wv && wr;
			@(posedge clk);
			if (ah)
				awv <= 1'h0;
			if (wh)
				wv <= 1'h0;
			@(negedge clk);
		end
		while (!bv)
			@(negedge clk);
		resp = br;
		@(posedge clk);
		bre <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat,
		output logic [1:0] resp);
		@(posedge clk);
		arv <= 1'h1;
		ara <= a;
		rre <= 1'h1;
		@(negedge clk);
		while (!arr)
			@(negedge clk);
		@(posedge clk);
		arv <= 1'h0;
		@(negedge clk);
		while (!rv)
			@(negedge clk);
		dat = rd;
		resp = rr;
		@(posedge clk);
		rre <= 1'h0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, 32'h0);
	endtask

	// Issue a start, then count cycles from the start edge to done
	task automatic step(input logic [7:0] a, input logic [31:0] dat,
		input int cyc, input int dx, input int dy, input int np);
		int n;
		ex += dx;
		ey += dy;
		ep += np;
		axi_wr(a, dat, r);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
			if (n == 1)
			begin
				chk(busy, 1'h1);
				chk(done, 1'h0);
			end
		end
		while (!done && n < 1000);
		chk(n, cyc);
		chk(busy, 1'h0);
		chk(xq, ex);
		chk(yq, ey);
		chk(pc, ep);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test;
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		chk(busy, 1'h0);
		chk(done, 1'h0);
		chk(irq, 1'h0);
		rd_chk(8'h08, 32'h0);
		axi_wr(8'h00, 32'hffff_fcc5, r);
		chk(r, 2'h0);
		rd_chk(8'h00, 32'h5);
		axi_wr(8'h18, 32'h1, r);
		axi_wr(8'h0c, 32'h0, r);
		step(8'h04, 32'h100, 20, 1, 1, 2);
		@(negedge clk);
		chk(irq, 1'h1);
		rd_chk(8'h10, 32'h1);
		axi_wr(8'h0c, 32'h1, r);
		step(8'h04, 32'h100, 13, 1, 1, 2);
		rd_chk(8'h00, 32'h5);
		axi_wr(8'h14, 32'h1, r);
		rd_chk(8'h10, 32'h0);
		chk(irq, 1'h0);
		axi_wr(8'h18, 32'h0, r);
		step(8'h00, 32'h10a, 13, -1, -1, 2);
		@(negedge clk);
		chk(irq, 1'h0);
		rd_chk(8'h10, 32'h1);
		axi_wr(8'h18, 32'h1, r);
		@(negedge clk);
		chk(irq, 1'h1);
		step(8'h00, 32'h107, 13, 0, 1, 1);
		step(8'h00, 32'h10b, 13, 0, -1, 1);
		step(8'h00, 32'h110, 40, 0, 0, 1);
		chk(pd, 1'h1);
		axi_wr(8'h0c, 32'h0, r);
		// Pen and axis together only because a dotted segment is wanted
		step(8'h00, 32'h111, 40, 1, 0, 2);
		chk(cc, 1);
		axi_wr(8'h00, 32'h101, r);
		ex += 1;
		ep += 1;
		axi_wr(8'h04, 32'h200, r);
		@(negedge clk);
		chk(busy, 1'h0);
		chk(done, 1'h0);
		repeat (30) @(negedge clk);
		chk(done, 1'h0);
		rd_chk(8'h00, 32'h1);
		axi_wr(8'h1c, 32'h3f, r);
		chk(r, 2'h2);
		axi_rd(8'h1c, d, r);
		chk(d, 32'h0);
		chk(r, 2'h2);
		axi_wr(8'h00, 32'h101, r);
		ex += 1;
		ep += 1;
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		chk(busy, 1'h0);
		chk(done, 1'h0);
		chk(irq, 1'h0);
		repeat (30) @(negedge clk);
		chk(done, 1'h0);
		// A low clock enable freezes the step timer along with the flags
		axi_wr(8'h00, 32'h101, r);
		ex += 1;
		ep += 1;
		@(posedge clk);
		ce <= 1'h0;
		repeat (40) @(negedge clk);
		chk(busy, 1'h1);
		chk(done, 1'h0);
		@(posedge clk);
		ce <= 1'h1;
		repeat (18) @(negedge clk);
		chk(done, 1'h0);
		@(negedge clk);
		chk(done, 1'h1);
		chk(xq, ex);
		// The plot ends with the pen lifted off the paper
		step(8'h00, 32'h120, 40, 0, 0, 1);
		chk(pd, 1'h0);
		end_of_test;
	end
endmodule
